/* verilog/lpec_top.sv */
// Purpose: Loopbacks, pattern generator/checker and error counter
// Assumes: Link clocks and pins sampled by ref_clk_i
// Notes: Jitter attenuator and clock recovery sit outside
`timescale 1ns/1ps
module lpec_code_det
  import lpec_pkg::*;
#(
  parameter int unsigned INTEG_CYC = INTEG_CYCLES
) (
  // Clock and reset
  input wire logic ref_clk_i,
  input wire logic srst_i,
  // Received bits
  input wire logic bit_stb_i,
  input wire logic bit_i,
  // Code
  input wire logic [2:0] len_i,
  input wire logic [15:0] code_i,
  // Result
  output logic det_o
);
  logic [15:0] hist;
  logic [31:0] tmr;
  logic [19:0] errs;
  logic seen;
  wire [4:0] len_bits = (len_i == 3'h7) ? 5'h10 : {2'h0, len_i} + 5'h01;
  wire [15:0] mask = 16'hffff >> (5'h10 - len_bits);
  wire [15:0] next_hist = {hist[14:0], bit_i};
  wire [15:0] ref_bits = code_i >> (5'h10 - len_bits);
  wire aligned = ((next_hist ^ ref_bits) & mask) == 16'h0000;
  wire [3:0] back = 4'(len_bits - 5'h01);
  wire period_err = bit_i != hist[back];
  wire tmr_done = tmr >= INTEG_CYC - 1;

  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      hist <= 16'h0000;
      tmr <= 32'h0;
      errs <= 20'h0;
      seen <= 1'b0;
      det_o <= 1'b0;
    end else begin
      if (bit_stb_i) begin
        hist <= next_hist;
      end
      tmr <= tmr_done ? 32'h0 : tmr + 32'h1;
      if (tmr_done) begin
        det_o <= seen && (errs <= CODE_ERR_LIMIT);
        errs <= 20'h0;
        seen <= 1'b0;
      end else if (bit_stb_i) begin
        if (period_err && errs != 20'hfffff) begin
          errs <= errs + 20'h1;
        end
        if (aligned) begin
          seen <= 1'b1;
        end
      end
    end
  end
endmodule

module lpec_top
  import lpec_pkg::*;
#(
  parameter int unsigned QUAL_CYC = QUAL_CYCLES,
  parameter int unsigned INTEG_CYC = INTEG_CYCLES
) (
  // Clock and reset
  input wire logic ref_clk_i,
  input wire logic srst_i,
  // Register port
  input wire logic [4:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic reg_wr_i,
  output logic [7:0] reg_rdata_o,
  // System transmit side
  input wire logic tx_clock_in_i,
  input wire logic tx_pos_rail_i,
  input wire logic tx_neg_rail_i,
  // System receive side
  output logic rx_clock_o,
  output logic rx_pos_rail_o,
  output logic rx_neg_rail_o,
  output logic rx_valid_o,
  input wire logic rx_ready_i,
  output logic rx_buf_ready_o,
  // Line side
  input wire logic rec_clock_i,
  input wire logic line_rx_a_i,
  input wire logic line_rx_b_i,
  output logic line_tx_a_o,
  output logic line_tx_b_o,
  // Pattern error
  output logic pattern_error_pulse_out_o
);
  // ----------------------------------------
  // Registers and pin synchronisers
  // ----------------------------------------
  logic [7:0] common_control_1, common_control_2, common_control_3, common_control_6;
  logic [7:0] code_len, loop_up_pattern_first_byte, loop_up_pattern_second_byte;
  logic [7:0] loop_down_pattern_first_byte, loop_down_pattern_second_byte;
  logic [15:0] err_cnt, err_latched;
  logic latch_q;
  logic [5:0] sync1, sync2;
  logic [1:0] clk_q;
  logic [7:0] status_flags, next_rdata;

  always_ff @(posedge ref_clk_i) begin
    sync1 <= {line_rx_b_i, line_rx_a_i, rec_clock_i, tx_neg_rail_i, tx_pos_rail_i,
              tx_clock_in_i};
    sync2 <= sync1;
    clk_q <= {sync2[3], sync2[0]};
  end

  wire tx_stb = sync2[0] & ~clk_q[0];
  wire rec_stb = sync2[3] & ~clk_q[1];
  wire std_t1 = common_control_1[C1_STD];
  wire nrz = common_control_1[C1_NRZ];
  wire zsd = common_control_2[C2_ZSD];
  wire ones = common_control_3[C3_ONES];
  wire prbs_en = common_control_3[C3_PRBS];
  wire near = common_control_6[C6_NEAR];
  wire far = common_control_6[C6_FAR];
  wire auto_en = common_control_6[C6_AUTO];
  wire line_driver_loopback = common_control_6[C6_ALB];
  wire [2:0] sel = common_control_6[2:0];

  // ----------------------------------------
  // Loop code detectors and auto loopback
  // ----------------------------------------
  logic up_det, dn_det;
  lpec_auto_e auto_st;
  logic [31:0] qual_cnt;
  logic rx_stb, rx_p, rx_n;

  lpec_code_det #(.INTEG_CYC(INTEG_CYC)) u_up_det (
    .ref_clk_i(ref_clk_i),
    .srst_i(srst_i),
    .bit_stb_i(rx_stb),
    .bit_i(rx_p | rx_n),
    .len_i(code_len[5:3]),
    .code_i({loop_up_pattern_first_byte, loop_up_pattern_second_byte}),
    .det_o(up_det)
  );

  lpec_code_det #(.INTEG_CYC(INTEG_CYC)) u_dn_det (
    .ref_clk_i(ref_clk_i),
    .srst_i(srst_i),
    .bit_stb_i(rx_stb),
    .bit_i(rx_p | rx_n),
    .len_i(code_len[2:0]),
    .code_i({loop_down_pattern_first_byte, loop_down_pattern_second_byte}),
    .det_o(dn_det)
  );

  wire auto_far_loopback = auto_st == LPEC_AUTO_ON;
  wire watch = auto_far_loopback ? dn_det : up_det;
  wire qual_done = watch && (qual_cnt >= QUAL_CYC - 1);

  always_ff @(posedge ref_clk_i) begin
    if (srst_i || !auto_en) begin
      auto_st <= LPEC_AUTO_OFF;
      qual_cnt <= 32'h0;
    end else begin
      qual_cnt <= (watch && !qual_done) ? qual_cnt + 32'h1 : 32'h0;
      unique case (auto_st)
        LPEC_AUTO_OFF: if (qual_done) auto_st <= LPEC_AUTO_ON;
        LPEC_AUTO_ON: if (qual_done) auto_st <= LPEC_AUTO_OFF;
      endcase
    end
  end

  // ----------------------------------------
  // Transmit path and pattern generator
  // ----------------------------------------
  logic [19:0] gen;
  logic ami_pol;
  wire far_eff = far | auto_far_loopback;
  wire tx_upd = far_eff ? rec_stb : tx_stb;
  wire gen_fb = std_t1 ? gen[19] ^ gen[16] : gen[14] ^ gen[13];
  wire src_mark = ones | (prbs_en & gen_fb);
  wire use_gen = ones | (prbs_en & ~far_eff);
  wire next_tx_a = use_gen ? src_mark & ~ami_pol : far_eff ? sync2[4] : sync2[1];
  wire next_tx_b = use_gen ? src_mark & ami_pol : far_eff ? sync2[5] : sync2[2];

  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      gen <= 20'h00001;
      ami_pol <= 1'b0;
      line_tx_a_o <= 1'b0;
      line_tx_b_o <= 1'b0;
    end else if (tx_upd) begin
      line_tx_a_o <= next_tx_a;
      line_tx_b_o <= next_tx_b;
      if (use_gen && src_mark) begin
        ami_pol <= ~ami_pol;
      end
      if (prbs_en) begin
        gen <= {gen[18:0], gen_fb};
      end
    end
  end

  // ----------------------------------------
  // Receive source and line decoding
  // ----------------------------------------
  logic last_pol, seen_mark, prev_v, have_v, last_vpol;
  logic [4:0] zrun;
  assign rx_stb = (near | line_driver_loopback) ? tx_stb : rec_stb;
  assign rx_p = near ? sync2[1] : line_driver_loopback ? line_tx_a_o : sync2[4];
  assign rx_n = near ? sync2[2] : line_driver_loopback ? line_tx_b_o : sync2[5];
  wire mark = rx_p | rx_n;
  wire bpv_raw = mark & seen_mark & (rx_p == last_pol);
  wire cw_e1 = zrun >= 5'h02;
  wire cw_t1 = (zrun == 5'h03) | ((zrun == 5'h01) & prev_v);
  wire cw = ~zsd & (std_t1 ? cw_t1 : cw_e1);
  wire bipolar_violation = bpv_raw & ~cw;
  wire cv = ~std_t1 & ~zsd & bpv_raw & have_v & (rx_p == last_vpol);
  wire [4:0] exz_thr = std_t1 ? (zsd ? EXZ_T1_AMI : EXZ_T1_B8ZS) : EXZ_E1;
  wire excess_zeros = ~mark & (zrun == exz_thr - 5'h01);
  wire [3:0] e1_evt = {bipolar_violation | excess_zeros, cv | excess_zeros, bipolar_violation, cv};
  wire line_evt = std_t1 ? (sel[0] ? bipolar_violation | excess_zeros : bipolar_violation) : e1_evt[sel[1:0]];

  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      last_pol <= 1'b0;
      seen_mark <= 1'b0;
      prev_v <= 1'b0;
      have_v <= 1'b0;
      last_vpol <= 1'b0;
      zrun <= 5'h00;
    end else if (rx_stb) begin
      zrun <= mark ? 5'h00 : (zrun == 5'h1f ? zrun : zrun + 5'h01);
      if (mark) begin
        last_pol <= rx_p;
        seen_mark <= 1'b1;
        prev_v <= bpv_raw;
      end
      if (bpv_raw) begin
        have_v <= 1'b1;
        last_vpol <= rx_p;
      end
    end
  end

  // ----------------------------------------
  // Pattern synchroniser
  // ----------------------------------------
  logic [19:0] rh;
  logic [6:0] run_e1, run_t1, win_cnt;
  logic [63:0] errwin;
  logic locked, lk_t1;
  wire err_e1 = mark ^ rh[14] ^ rh[13];
  wire err_t1 = mark ^ rh[19] ^ rh[16];
  wire prbs_err = lk_t1 ? err_t1 : err_e1;
  wire [6:0] next_win = win_cnt + {6'h00, prbs_err} - {6'h00, errwin[63]};
  wire hit_e1 = (run_e1 == PRBS_SYNC_BITS - 7'h01) & ~err_e1;
  wire hit_t1 = (run_t1 == PRBS_SYNC_BITS - 7'h01) & ~err_t1;
  wire lose = next_win >= PRBS_LOSS_ERRS;

  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      rh <= 20'h00000;
      run_e1 <= 7'h00;
      run_t1 <= 7'h00;
      win_cnt <= 7'h00;
      errwin <= 64'h0;
      locked <= 1'b0;
      lk_t1 <= 1'b0;
      pattern_error_pulse_out_o <= 1'b1;
    end else if (rx_stb) begin
      rh <= {rh[18:0], mark};
      if (!locked) begin
        run_e1 <= (err_e1 || rh[14:0] == 15'h0000) ? 7'h00 : run_e1 + 7'h01;
        run_t1 <= (err_t1 || rh == 20'h00000) ? 7'h00 : run_t1 + 7'h01;
        errwin <= 64'h0;
        win_cnt <= 7'h00;
        locked <= hit_e1 | hit_t1;
        lk_t1 <= hit_t1 & ~hit_e1;
        pattern_error_pulse_out_o <= ~(hit_e1 | hit_t1);
      end else if (lose) begin
        locked <= 1'b0;
        run_e1 <= 7'h00;
        run_t1 <= 7'h00;
        pattern_error_pulse_out_o <= 1'b1;
      end else begin
        errwin <= {errwin[62:0], prbs_err};
        win_cnt <= next_win;
        pattern_error_pulse_out_o <= prbs_err;
      end
    end
  end

  // ----------------------------------------
  // Error counter
  // ----------------------------------------
  wire cnt_evt = rx_stb & (sel[2] ? locked & prbs_err : line_evt);
  wire latch = common_control_1[C1_LATCH] & ~latch_q;

  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      err_cnt <= 16'h0000;
      err_latched <= 16'h0000;
      latch_q <= 1'b0;
    end else begin
      latch_q <= common_control_1[C1_LATCH];
      if (latch) begin
        err_latched <= err_cnt;
        err_cnt <= {15'h0000, cnt_evt};
      end else if (cnt_evt && err_cnt != 16'hffff) begin
        err_cnt <= err_cnt + 16'h0001;
      end
    end
  end

  // ----------------------------------------
  // Receive buffer, two entries
  // ----------------------------------------
  logic [1:0] buf_p, buf_n;
  logic [1:0] buf_cnt;
  wire ent_p = nrz ? mark : rx_p;
  wire ent_n = nrz ? ~sel[2] & line_evt : rx_n;
  wire pop = rx_valid_o & rx_ready_i;
  wire push = rx_stb & ((buf_cnt != 2'h2) | pop);
  wire [1:0] next_cnt = buf_cnt + {1'b0, push} - {1'b0, pop};
  wire wr_idx = (buf_cnt - {1'b0, pop}) != 2'h0;

  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      buf_p <= 2'h0;
      buf_n <= 2'h0;
      buf_cnt <= 2'h0;
      rx_valid_o <= 1'b0;
      rx_buf_ready_o <= 1'b1;
      rx_clock_o <= 1'b0;
    end else begin
      if (pop) begin
        buf_p[0] <= buf_p[1];
        buf_n[0] <= buf_n[1];
      end
      if (push) begin
        buf_p[wr_idx] <= ent_p;
        buf_n[wr_idx] <= ent_n;
      end
      buf_cnt <= next_cnt;
      rx_valid_o <= next_cnt != 2'h0;
      rx_buf_ready_o <= next_cnt != 2'h2;
      rx_clock_o <= (near | line_driver_loopback) ? sync2[0] : sync2[3];
    end
  end

  assign rx_pos_rail_o = buf_p[0];
  assign rx_neg_rail_o = buf_n[0];

  // ----------------------------------------
  // Register port
  // ----------------------------------------
  always_comb begin
    status_flags = 8'h00;
    status_flags[ST_UP] = up_det;
    status_flags[ST_DN] = dn_det;
    status_flags[ST_AUTO] = auto_far_loopback;
    status_flags[ST_LOCK] = locked;
  end

  always_comb begin
    unique case (reg_addr_i)
      ADR_CTL1: next_rdata = common_control_1;
      ADR_CTL2: next_rdata = common_control_2;
      ADR_CTL3: next_rdata = common_control_3;
      ADR_CTL6: next_rdata = common_control_6;
      ADR_STAT: next_rdata = status_flags;
      ADR_CODE_LEN: next_rdata = code_len;
      ADR_UP1: next_rdata = loop_up_pattern_first_byte;
      ADR_UP2: next_rdata = loop_up_pattern_second_byte;
      ADR_DN1: next_rdata = loop_down_pattern_first_byte;
      ADR_DN2: next_rdata = loop_down_pattern_second_byte;
      ADR_ECR_HI: next_rdata = err_latched[15:8];
      ADR_ECR_LO: next_rdata = err_latched[7:0];
      default: next_rdata = 8'h00;
    endcase
  end

  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      common_control_1 <= REG_RST;
      common_control_2 <= REG_RST;
      common_control_3 <= REG_RST;
      common_control_6 <= REG_RST;
      code_len <= REG_RST;
      loop_up_pattern_first_byte <= REG_RST;
      loop_up_pattern_second_byte <= REG_RST;
      loop_down_pattern_first_byte <= REG_RST;
      loop_down_pattern_second_byte <= REG_RST;
      reg_rdata_o <= 8'h00;
    end else begin
      reg_rdata_o <= next_rdata;
      if (reg_wr_i) begin
        unique case (reg_addr_i)
          ADR_CTL1: common_control_1 <= reg_wdata_i;
          ADR_CTL2: common_control_2 <= reg_wdata_i;
          ADR_CTL3: common_control_3 <= reg_wdata_i;
          ADR_CTL6: common_control_6 <= reg_wdata_i;
          ADR_CODE_LEN: code_len <= reg_wdata_i;
          ADR_UP1: loop_up_pattern_first_byte <= reg_wdata_i;
          ADR_UP2: loop_up_pattern_second_byte <= reg_wdata_i;
          ADR_DN1: loop_down_pattern_first_byte <= reg_wdata_i;
          ADR_DN2: loop_down_pattern_second_byte <= reg_wdata_i;
          default: ;
        endcase
      end
    end
  end

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  far_path_a: assert property (@(posedge ref_clk_i) disable iff (srst_i)
    far_eff && !use_gen && rec_stb |=>
    line_tx_a_o == $past(sync2[4]) && line_tx_b_o == $past(sync2[5]))
    else $error("far loopback data not sent");
  auto_entry_a: assert property (@(posedge ref_clk_i) disable iff (srst_i)
    $rose(auto_far_loopback) |-> $past(up_det) && $past(qual_cnt) >= QUAL_CYC - 1)
    else $error("auto loopback entered early");
  auto_exit_a: assert property (@(posedge ref_clk_i) disable iff (srst_i)
    $fell(auto_far_loopback) && $past(auto_en) |->
    $past(dn_det) && $past(qual_cnt) >= QUAL_CYC - 1)
    else $error("auto loopback left early");
  auto_off_a: assert property (@(posedge ref_clk_i) disable iff (srst_i)
    !auto_en |=> !auto_far_loopback)
    else $error("auto loopback kept while disabled");
  near_source_a: assert property (@(posedge ref_clk_i) disable iff (srst_i)
    near && tx_stb |-> rx_stb && rx_p == sync2[1] && rx_n == sync2[2])
    else $error("near loopback source wrong");
  ones_line_a: assert property (@(posedge ref_clk_i) disable iff (srst_i)
    ones && tx_upd |=> line_tx_a_o != line_tx_b_o)
    else $error("all ones not sent");
  unlocked_high_a: assert property (@(posedge ref_clk_i) disable iff (srst_i)
    !locked && rx_stb && !(hit_e1 || hit_t1) |=> pattern_error_pulse_out_o)
    else $error("error output low before lock");
  lock_loss_a: assert property (@(posedge ref_clk_i) disable iff (srst_i)
    locked && rx_stb && win_cnt + 7'h01 >= PRBS_LOSS_ERRS && prbs_err
    && !errwin[63] |=> !locked)
    else $error("lock kept at error limit");
  latch_copy_a: assert property (@(posedge ref_clk_i) disable iff (srst_i)
    latch |=> err_latched == $past(err_cnt) && err_cnt <= 16'h0001)
    else $error("count latch failed");
  count_sat_a: assert property (@(posedge ref_clk_i) disable iff (srst_i)
    err_cnt == 16'hffff && !latch |=> err_cnt == 16'hffff)
    else $error("error counter wrapped");
endmodule

/* verilog/lpec_pkg.sv */
// Purpose: Constants for the loopback, pattern and error counter block
// Assumes: 200 MHz reference clock, 8-bit register port
// Notes: Register reset values are all zero
package lpec_pkg;
  // ----------------------------------------
  // Register offsets
  // ----------------------------------------
  localparam logic [4:0] ADR_CTL1 = 5'h01;
  localparam logic [4:0] ADR_CTL2 = 5'h02;
  localparam logic [4:0] ADR_CTL3 = 5'h03;
  localparam logic [4:0] ADR_CTL6 = 5'h06;
  localparam logic [4:0] ADR_STAT = 5'h08;
  localparam logic [4:0] ADR_CODE_LEN = 5'h0a;
  localparam logic [4:0] ADR_UP1 = 5'h0d;
  localparam logic [4:0] ADR_UP2 = 5'h0e;
  localparam logic [4:0] ADR_DN1 = 5'h0f;
  localparam logic [4:0] ADR_DN2 = 5'h10;
  localparam logic [4:0] ADR_ECR_HI = 5'h11;
  localparam logic [4:0] ADR_ECR_LO = 5'h12;
  localparam logic [7:0] REG_RST = 8'h00;
  // ----------------------------------------
  // Field positions
  // ----------------------------------------
  localparam int C1_STD = 7;
  localparam int C1_NRZ = 6;
  localparam int C1_LATCH = 4;
  localparam int C2_ZSD = 3;
  localparam int C3_ONES = 7;
  localparam int C3_PRBS = 4;
  localparam int C6_NEAR = 7;
  localparam int C6_FAR = 6;
  localparam int C6_AUTO = 5;
  localparam int C6_ALB = 4;
  localparam int C6_SEL2 = 2;
  localparam int ST_UP = 7;
  localparam int ST_DN = 6;
  localparam int ST_AUTO = 3;
  localparam int ST_LOCK = 0;
  // ----------------------------------------
  // Timing and thresholds
  // ----------------------------------------
  localparam int unsigned CLK_HZ = 200_000_000;
  localparam int unsigned QUAL_TIME_S = 5;
  localparam int unsigned QUAL_CYCLES = QUAL_TIME_S * CLK_HZ;
  localparam int unsigned INTEG_TIME_MS = 48;
  localparam int unsigned INTEG_CYCLES = INTEG_TIME_MS * (CLK_HZ / 1000);
  localparam logic [19:0] CODE_ERR_LIMIT = 20'h003e8;
  localparam logic [6:0] PRBS_SYNC_BITS = 7'h40;
  localparam logic [6:0] PRBS_LOSS_ERRS = 7'h06;
  localparam logic [4:0] EXZ_E1 = 5'h04;
  localparam logic [4:0] EXZ_T1_B8ZS = 5'h08;
  localparam logic [4:0] EXZ_T1_AMI = 5'h10;
  typedef enum logic {LPEC_AUTO_OFF, LPEC_AUTO_ON} lpec_auto_e;
endpackage

/* test/lpec_framer.sv */
// Purpose: System-side framer model driving transmit rails
// Assumes: 48 ns link clock, one bit per rising edge
// Notes: Clock stands still between bits; rails invert when released
`timescale 1ns/1ps
module lpec_framer (
  // Transmit rails
  output logic tx_clock_o,
  output logic tx_pos_o,
  output logic tx_neg_o
);
  initial begin
    tx_clock_o = 1'b0;
    tx_pos_o = 1'b0;
    tx_neg_o = 1'b1;
  end
  // Rails stable around the rising edge
  task automatic send(input logic p, input logic n);
    tx_pos_o = p;
    tx_neg_o = n;
    #12 tx_clock_o = 1'b1;
    #24 tx_clock_o = 1'b0;
    #12;
    tx_pos_o = ~p;
    tx_neg_o = ~n;
  endtask
endmodule

/* test/lpec_top_bench.sv */
// Purpose: Self-checking bench for the loopback and error counter block
// Assumes: Shortened qualification and integration counts
// Notes: Receive stream compared against a queue of expected marks
`timescale 1ns/1ps
module lpec_top_bench;
  import lpec_pkg::*;
  logic ref_clk_i = 0, srst_i = 1, reg_wr_i = 0, rx_ready_i = 0;
  logic [4:0] reg_addr_i = '0;
  logic [7:0] reg_wdata_i = '0, reg_rdata_o, rv;
  logic rec_clock_i = 0, line_rx_a_i = 0, line_rx_b_i = 0;
  logic tx_clock_in_i, tx_pos_rail_i, tx_neg_rail_i;
  logic rx_clock_o, rx_pos_rail_o, rx_neg_rail_o, rx_valid_o, rx_buf_ready_o;
  logic line_tx_a_o, line_tx_b_o, pattern_error_pulse_out_o;
  logic watch = 0, far = 0, rdy = 0, pol = 0;
  logic [1:0] m, q[$];
  int bad_count = 0, checked = 0, cyc = 0;
  lpec_framer i_frm (.tx_clock_o(tx_clock_in_i), .tx_pos_o(tx_pos_rail_i),
    .tx_neg_o(tx_neg_rail_i));
  lpec_top #(.QUAL_CYC(200), .INTEG_CYC(100)) i_dut (.ref_clk_i(ref_clk_i),
    .srst_i(srst_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
    .reg_wr_i(reg_wr_i), .reg_rdata_o(reg_rdata_o), .tx_clock_in_i(tx_clock_in_i),
    .tx_pos_rail_i(tx_pos_rail_i), .tx_neg_rail_i(tx_neg_rail_i),
    .rx_clock_o(rx_clock_o), .rx_pos_rail_o(rx_pos_rail_o),
    .rx_neg_rail_o(rx_neg_rail_o), .rx_valid_o(rx_valid_o), .rx_ready_i(rx_ready_i),
    .rx_buf_ready_o(rx_buf_ready_o), .rec_clock_i(rec_clock_i),
    .line_rx_a_i(line_rx_a_i), .line_rx_b_i(line_rx_b_i), .line_tx_a_o(line_tx_a_o),
    .line_tx_b_o(line_tx_b_o), .pattern_error_pulse_out_o(pattern_error_pulse_out_o));
  // ----------------------------------------
  // Clock, consumer stalls, timeout
  // ----------------------------------------
  initial begin
    forever #2.5 ref_clk_i = ~ref_clk_i;
  end
  // Consumer stalls; head checked at the edge before it is taken
  always @(negedge ref_clk_i) begin
    rdy = ($urandom % 4) != 0;
    rx_ready_i <= rdy;
    if (watch && rx_valid_o === 1'b1 && rdy) begin
      if (q.size() == 0) begin
        chk(8'h0, 8'h1, "unexpected receive bit");
      end else begin
        chk({6'h0, rx_pos_rail_o, rx_neg_rail_o}, {6'h0, q.pop_front()}, "rx rails");
      end
    end
  end
  always @(posedge ref_clk_i) begin
    cyc++;
    if (cyc == 20000) begin
      bad_count++;
      results();
    end
  end
  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string s);
    checked++;
    if (got !== exp) begin
      bad_count++;
      $display("ERROR %0t: %s got %h exp %h", $time, s, got, exp);
    end
  endtask
  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    @(negedge ref_clk_i);
    reg_addr_i = a;
    reg_wdata_i = d;
    reg_wr_i = 1'b1;
    @(negedge ref_clk_i);
    reg_wr_i = 1'b0;
  endtask
  task automatic rd(input logic [4:0] a, input logic [7:0] e, input logic [7:0] k);
    @(negedge ref_clk_i);
    reg_addr_i = a;
    @(negedge ref_clk_i);
    rv = reg_rdata_o & k;
    chk(rv, e, "register read");
  endtask
  task automatic lbit(input logic p, input logic n);
    line_rx_a_i = p;
    line_rx_b_i = n;
    #12 rec_clock_i = 1'b1;
    #24 rec_clock_i = 1'b0;
    #12;
    if (far) begin
      chk({6'h0, line_tx_a_o, line_tx_b_o}, {6'h0, p, n}, "line tx");
    end
    line_rx_a_i = ~p;
    line_rx_b_i = ~n;
  endtask
  task automatic latch();
    wr(ADR_CTL1, 8'h10);
    wr(ADR_CTL1, 8'h00);
  endtask
  task automatic cnt(input logic [7:0] sel, input int np, input int nz,
      input logic [15:0] e);
    wr(ADR_CTL6, sel);
    lbit(1'b0, 1'b1);
    latch();
    repeat (np) lbit(1'b1, 1'b0);
    repeat (nz) lbit(1'b0, 1'b0);
    latch();
    rd(ADR_ECR_HI, e[15:8], 8'hff);
    rd(ADR_ECR_LO, e[7:0], 8'hff);
  endtask
  function automatic logic [1:0] mark();
    int r;
    r = $urandom % 3;
    return (r == 0) ? 2'b00 : (r == 1) ? 2'b10 : 2'b01;
  endfunction
  task automatic results();
    $display("Comparisons %0d, mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    void'($urandom(2));
    repeat (2) @(posedge ref_clk_i);
    @(negedge ref_clk_i);
    srst_i = 1'b0;
    chk({7'h0, pattern_error_pulse_out_o}, 8'h1, "error out unlocked");
    rd(ADR_DN1, REG_RST, 8'hff);
    rv = 8'($urandom);
    wr(ADR_DN1, rv);
    rd(ADR_DN1, rv, 8'hff);
    wr(ADR_DN2, 8'h3c);
    rd(ADR_DN2, 8'h3c, 8'hff);
    rd(5'h1f, 8'h00, 8'hff);
    wr(ADR_CTL3, 8'h80);
    wr(ADR_CTL6, 8'h80);
    watch = 1'b1;
    repeat (40) begin
      m = mark();
      q.push_back(m);
      fork
        i_frm.send(m[1], m[0]);
        lbit(m[0], m[1]);
      join
      chk({6'h0, line_tx_a_o, line_tx_b_o}, {6'h0, ~pol, pol}, "all ones");
      pol = ~pol;
    end
    repeat (40) @(negedge ref_clk_i);
    chk(8'(q.size()), 8'h0, "receive bits missing");
    watch = 1'b0;
    wr(ADR_CTL3, 8'h00);
    wr(ADR_CTL6, 8'h40);
    far = 1'b1;
    repeat (20) begin
      m = mark();
      fork
        i_frm.send(m[0], m[1]);
        lbit(m[1], m[0]);
      join
    end
    far = 1'b0;
    wr(ADR_CTL2, 8'h08);
    cnt(8'h01, 5, 0, 16'h0004);
    cnt(8'h03, 0, 4, 16'h0001);
    wr(ADR_CTL1, 8'h40);
    watch = 1'b1;
    q.push_back(2'b10);
    lbit(1'b1, 1'b0);
    q.push_back(2'b11);
    lbit(1'b1, 1'b0);
    q.push_back(2'b00);
    lbit(1'b0, 1'b0);
    q.push_back(2'b10);
    lbit(1'b0, 1'b1);
    repeat (20) @(negedge ref_clk_i);
    chk(8'(q.size()), 8'h0, "nrz bits missing");
    watch = 1'b0;
    wr(ADR_CTL1, 8'h00);
    wr(ADR_UP1, 8'h80);
    wr(ADR_DN1, 8'hc0);
    wr(ADR_CODE_LEN, 8'h09);
    wr(ADR_CTL6, 8'h20);
    for (int k = 0; k < 2; k++) begin
      repeat (40) begin
        lbit(1'b1, 1'b0);
        lbit(1'b0, 1'b0);
      end
      rd(ADR_STAT, 8'h08, 8'h08);
      if (k == 0) begin
        repeat (80) lbit(1'b1, 1'b0);
        rd(ADR_STAT, 8'h00, 8'h08);
      end
    end
    wr(ADR_CTL6, 8'h00);
    rd(ADR_STAT, 8'h00, 8'h08);
    wr(ADR_CTL6, 8'h10);
    wr(ADR_CTL3, 8'h10);
    repeat (150) i_frm.send(1'b0, 1'b0);
    repeat (20) @(negedge ref_clk_i);
    chk({7'h0, pattern_error_pulse_out_o}, 8'h0, "error out locked");
    rd(ADR_STAT, 8'h01, 8'h01);
    results();
  end
endmodule
